// ==== core/servo_dir_regs.svh ====
`ifndef SERVO_DIR_REGS_SVH
`define SERVO_DIR_REGS_SVH
// ---------------------------------------------------------------
// setting ranges and defaults
// ---------------------------------------------------------------
`define PITCH_WIDTH 23
`define PITCH_MAX 23'h640000
`define PITCH_DEFAULT 23'h000000
`define SERIAL_WIDTH 56
// seven ascii asterisks
`define SERIAL_PLACEHOLDER 56'h2A2A2A2A2A2A2A
`endif

// ==== core/servo_dir_pkg.sv ====
`default_nettype none
package servo_dir_pkg;
  typedef enum logic [1:0]
  {
    REF_IDLE = 2'b00,
    REF_FORWARD = 2'b01,
    REF_REVERSE = 2'b10
  } ref_dir_t;
  typedef enum logic [1:0]
  {
    QUAD_00 = 2'b00,
    QUAD_01 = 2'b01,
    QUAD_11 = 2'b10,
    QUAD_10 = 2'b11
  } quad_state_t;
endpackage : servo_dir_pkg
`default_nettype wire

// ==== core/servo_direction_pitch_config.sv ====
// Overview of operation
// - rotary: select 0 forward=CCW, 1 forward=CW
// - pulses: forward B leads, reverse A leads
// - forward checks forward limit, reverse reverse
// - linear: select 0 forward counts up
// - pitch 0..6,553,600 taken at restart
// - linear with converter: pitch default at restart raises pitch alarm
// - linear, no converter: automatic pitch, manual ignored
// - linear: missing encoder parameters raise encoder alarm
// - linear: missing motor parameters raise alarm group when encoder parameters present
// - serial monitor shows asterisks for linear
`include "servo_dir_regs.svh"
`default_nettype none
module servo_direction_pitch_config
(
  // clock and reset
  input wire logic CLOCK,
  input wire logic RESET_N,
  // restart request, settings latched on it
  input wire logic RESTART,
  // settings
  input wire logic DIRECTION_SELECT_FIELD,
  input wire logic [`PITCH_WIDTH-1:0] SCALE_PITCH_SETTING,
  // encoder attachment
  input wire logic LINEAR_MOTOR,
  input wire logic CONVERTER_PRESENT,
  input wire logic [`PITCH_WIDTH-1:0] AUTO_PITCH,
  input wire logic ENCODER_PARAMS_PRESENT,
  input wire logic MOTOR_PARAMS_PRESENT,
  input wire logic [`SERIAL_WIDTH-1:0] ENCODER_SERIAL,
  // motion reference from the controller
  input wire logic FORWARD_STEP,
  input wire logic REVERSE_STEP,
  // travel limits, high means motion prohibited
  input wire logic FORWARD_TRAVEL_LIMIT,
  input wire logic REVERSE_TRAVEL_LIMIT,
  // motor drive
  output logic MOTOR_STEP,
  output logic MOTOR_CCW,
  output logic LIMIT_BLOCKED,
  // divided pulse outputs
  output logic DIVIDED_PULSE_A_OUT,
  output logic DIVIDED_PULSE_B_OUT,
  // pitch and alarms
  output logic [`PITCH_WIDTH-1:0] ACTIVE_PITCH,
  output logic PITCH_ALARM,
  output logic ENCODER_PARAM_ALARM,
  output logic MOTOR_PARAM_ALARMS,
  output logic [`SERIAL_WIDTH-1:0] SERIAL_MONITOR
);
  import servo_dir_pkg::*;

  // ---------------------------------------------------------------
  // settings latched at reset release and restart
  // ---------------------------------------------------------------
  logic restart_pending;
  logic next_restart_pending;
  logic dir_sel;
  logic next_dir_sel;
  logic [`PITCH_WIDTH-1:0] pitch;
  logic [`PITCH_WIDTH-1:0] next_pitch;
  logic pitch_alarm;
  logic next_pitch_alarm;
  logic enc_alarm;
  logic next_enc_alarm;
  logic mot_alarm;
  logic next_mot_alarm;
  logic [`SERIAL_WIDTH-1:0] serial;
  logic [`SERIAL_WIDTH-1:0] next_serial;

  always_comb
  begin
    next_restart_pending = 1'b0;
    next_dir_sel = dir_sel;
    next_pitch = pitch;
    next_pitch_alarm = pitch_alarm;
    next_enc_alarm = enc_alarm;
    next_mot_alarm = mot_alarm;
    next_serial = serial;
    // first edge after reset release acts as a restart
    if (restart_pending || RESTART)
    begin
      next_dir_sel = DIRECTION_SELECT_FIELD;
      next_pitch_alarm = 1'b0;
      if (LINEAR_MOTOR && !CONVERTER_PRESENT)
      begin
        next_pitch = AUTO_PITCH;
      end
      else if (LINEAR_MOTOR)
      begin
        // out-of-range values are clamped rather than accepted
        next_pitch = (SCALE_PITCH_SETTING > `PITCH_MAX) ? `PITCH_MAX
          : SCALE_PITCH_SETTING;
        next_pitch_alarm = (SCALE_PITCH_SETTING == `PITCH_DEFAULT);
      end
      else
      begin
        next_pitch = `PITCH_DEFAULT;
      end
      next_enc_alarm = LINEAR_MOTOR && !ENCODER_PARAMS_PRESENT;
      next_mot_alarm = LINEAR_MOTOR && ENCODER_PARAMS_PRESENT
        && !MOTOR_PARAMS_PRESENT;
      next_serial = LINEAR_MOTOR ? `SERIAL_PLACEHOLDER : ENCODER_SERIAL;
    end
  end

  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      restart_pending <= 1'b1;
      dir_sel <= 1'b0;
      pitch <= `PITCH_DEFAULT;
      pitch_alarm <= 1'b0;
      enc_alarm <= 1'b0;
      mot_alarm <= 1'b0;
      serial <= '0;
    end
    else
    begin
      restart_pending <= next_restart_pending;
      dir_sel <= next_dir_sel;
      pitch <= next_pitch;
      pitch_alarm <= next_pitch_alarm;
      enc_alarm <= next_enc_alarm;
      mot_alarm <= next_mot_alarm;
      serial <= next_serial;
    end
  end

  // ---------------------------------------------------------------
  // reference decode, limits and direction mapping
  // ---------------------------------------------------------------
  ref_dir_t ref_dir;
  logic blocked;
  logic any_alarm;
  logic next_step;
  logic next_ccw;
  logic next_blocked;

  always_comb
  begin
    // both steps at once cancel out
    case ({FORWARD_STEP, REVERSE_STEP})
      2'b10: ref_dir = REF_FORWARD;
      2'b01: ref_dir = REF_REVERSE;
      default: ref_dir = REF_IDLE;
    endcase
    blocked = (ref_dir == REF_FORWARD && FORWARD_TRAVEL_LIMIT)
      || (ref_dir == REF_REVERSE && REVERSE_TRAVEL_LIMIT);
    any_alarm = pitch_alarm || enc_alarm || mot_alarm;
    next_step = (ref_dir != REF_IDLE) && !blocked && !any_alarm;
    // ccw doubles as count-up for a linear motor
    next_ccw = (ref_dir == REF_FORWARD) ^ dir_sel;
    next_blocked = blocked;
  end

  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      MOTOR_STEP <= 1'b0;
      MOTOR_CCW <= 1'b0;
      LIMIT_BLOCKED <= 1'b0;
    end
    else
    begin
      MOTOR_STEP <= next_step;
      MOTOR_CCW <= next_ccw;
      LIMIT_BLOCKED <= next_blocked;
    end
  end

  // ---------------------------------------------------------------
  // divided pulse quadrature, independent of direction select
  // ---------------------------------------------------------------
  quad_state_t quad;
  quad_state_t next_quad;
  logic next_pulse_a;
  logic next_pulse_b;

  always_comb
  begin
    next_quad = quad;
    // forward walks 00-01-11-10: b rises first, so b leads
    if (next_step && ref_dir == REF_FORWARD)
    begin
      case (quad)
        QUAD_00: next_quad = QUAD_01;
        QUAD_01: next_quad = QUAD_11;
        QUAD_11: next_quad = QUAD_10;
        QUAD_10: next_quad = QUAD_00;
        default: next_quad = QUAD_00;
      endcase
    end
    else if (next_step && ref_dir == REF_REVERSE)
    begin
      case (quad)
        QUAD_00: next_quad = QUAD_10;
        QUAD_10: next_quad = QUAD_11;
        QUAD_11: next_quad = QUAD_01;
        QUAD_01: next_quad = QUAD_00;
        default: next_quad = QUAD_00;
      endcase
    end
    next_pulse_a = (next_quad == QUAD_11) || (next_quad == QUAD_10);
    next_pulse_b = (next_quad == QUAD_01) || (next_quad == QUAD_11);
  end

  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      quad <= QUAD_00;
      DIVIDED_PULSE_A_OUT <= 1'b0;
      DIVIDED_PULSE_B_OUT <= 1'b0;
    end
    else
    begin
      quad <= next_quad;
      DIVIDED_PULSE_A_OUT <= next_pulse_a;
      DIVIDED_PULSE_B_OUT <= next_pulse_b;
    end
  end

  // ---------------------------------------------------------------
  // status outputs
  // ---------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      ACTIVE_PITCH <= `PITCH_DEFAULT;
      PITCH_ALARM <= 1'b0;
      ENCODER_PARAM_ALARM <= 1'b0;
      MOTOR_PARAM_ALARMS <= 1'b0;
      SERIAL_MONITOR <= '0;
    end
    else
    begin
      ACTIVE_PITCH <= pitch;
      PITCH_ALARM <= pitch_alarm;
      ENCODER_PARAM_ALARM <= enc_alarm;
      MOTOR_PARAM_ALARMS <= mot_alarm;
      SERIAL_MONITOR <= serial;
    end
  end
endmodule : servo_direction_pitch_config
`default_nettype wire

// ==== dv/servo_dir_props.sv ====
`include "servo_dir_regs.svh"
`default_nettype none
module servo_dir_props
(
  // clock and reset
  input wire logic CLOCK,
  input wire logic RESET_N,
  // settings
  input wire logic RESTART,
  input wire logic LINEAR_MOTOR,
  input wire logic ENCODER_PARAMS_PRESENT,
  input wire logic MOTOR_PARAMS_PRESENT,
  // motion
  input wire logic FORWARD_STEP,
  input wire logic REVERSE_STEP,
  input wire logic MOTOR_STEP,
  input wire logic FORWARD_TRAVEL_LIMIT,
  input wire logic REVERSE_TRAVEL_LIMIT,
  // outputs watched
  input wire logic DIVIDED_PULSE_A_OUT,
  input wire logic DIVIDED_PULSE_B_OUT,
  input wire logic ENCODER_PARAM_ALARM,
  input wire logic MOTOR_PARAM_ALARMS,
  input wire logic [`SERIAL_WIDTH-1:0] SERIAL_MONITOR
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);
  logic a, b, f, r;
  assign a = DIVIDED_PULSE_A_OUT;
  assign b = DIVIDED_PULSE_B_OUT;
  assign f = FORWARD_STEP & ~REVERSE_STEP;
  assign r = REVERSE_STEP & ~FORWARD_STEP;
  sequence s_lin;
    RESTART && LINEAR_MOTOR;
  endsequence
  chk_fwd_limit: assert property (
    f && FORWARD_TRAVEL_LIMIT |=> !MOTOR_STEP) else $error("forward limit ignored");
  chk_rev_limit: assert property (
    r && REVERSE_TRAVEL_LIMIT |=> !MOTOR_STEP) else $error("reverse limit ignored");
  chk_fwd_quad: assert property (
    MOTOR_STEP && $past(f) |-> {a, b} == {$past(b), !$past(a)}) else $error("fwd phase");
  chk_rev_quad: assert property (
    MOTOR_STEP && $past(r) |-> {a, b} == {!$past(b), $past(a)}) else $error("rev phase");
  chk_quad_hold: assert property (
    !MOTOR_STEP |-> $stable({a, b})) else $error("pulse moved idle");
  chk_enc_alarm: assert property (
    s_lin ##0 !ENCODER_PARAMS_PRESENT |-> ##2 ENCODER_PARAM_ALARM) else $error("no enc alarm");
  chk_motor_alarm: assert property (
    s_lin ##0 (ENCODER_PARAMS_PRESENT && !MOTOR_PARAMS_PRESENT)
    |-> ##2 (MOTOR_PARAM_ALARMS && !ENCODER_PARAM_ALARM)) else $error("motor alarm");
  chk_serial_mask: assert property (
    s_lin |-> ##2 SERIAL_MONITOR == `SERIAL_PLACEHOLDER) else $error("serial shown");
endmodule : servo_dir_props
bind servo_direction_pitch_config servo_dir_props i_props (
  .CLOCK(CLOCK),
  .RESET_N(RESET_N),
  .RESTART(RESTART),
  .LINEAR_MOTOR(LINEAR_MOTOR),
  .ENCODER_PARAMS_PRESENT(ENCODER_PARAMS_PRESENT),
  .MOTOR_PARAMS_PRESENT(MOTOR_PARAMS_PRESENT),
  .FORWARD_STEP(FORWARD_STEP),
  .REVERSE_STEP(REVERSE_STEP),
  .MOTOR_STEP(MOTOR_STEP),
  .FORWARD_TRAVEL_LIMIT(FORWARD_TRAVEL_LIMIT),
  .REVERSE_TRAVEL_LIMIT(REVERSE_TRAVEL_LIMIT),
  .DIVIDED_PULSE_A_OUT(DIVIDED_PULSE_A_OUT),
  .DIVIDED_PULSE_B_OUT(DIVIDED_PULSE_B_OUT),
  .ENCODER_PARAM_ALARM(ENCODER_PARAM_ALARM),
  .MOTOR_PARAM_ALARMS(MOTOR_PARAM_ALARMS),
  .SERIAL_MONITOR(SERIAL_MONITOR)
);
`default_nettype wire

// ==== dv/motion_ctrl_model.sv ====
`default_nettype none
module motion_ctrl_model
(
  input wire logic clock,
  input wire logic [1:0] cmd,
  input wire logic pa,
  input wire logic pb,
  output logic fwd,
  output logic rev,
  output int pos
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] q = 2'h0;
  int count = 0;
  assign fwd = cmd[0];
  assign rev = cmd[1];
  assign pos = count;
  // only single gray steps count, a skipped state is lost
  always @(posedge clock)
  begin
    if ({pa, pb} == {q[0], ~q[1]})
      count <= count + 1;
    else if ({pa, pb} == {~q[0], q[1]})
      count <= count - 1;
    q <= {pa, pb};
  end
endmodule : motion_ctrl_model
`default_nettype wire

// ==== dv/servo_direction_pitch_config_tb.sv ====
`include "servo_dir_regs.svh"
`default_nettype none
module servo_direction_pitch_config_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, reset_n = 0, restart = 0, dir = 0, lin = 0, conv = 0, encp = 1, motp = 1;
  logic flim = 0, rlim = 0, mstep, ccw, blk, pa, pb, palm, ealm, malm, fwd, rev;
  logic [1:0] cmd = 2'h0;
  logic [`PITCH_WIDTH-1:0] pitch = 23'h0, apitch;
  logic [`SERIAL_WIDTH-1:0] ser;
  int pos, n_fail = 0, tests_run = 0;
  always #5 clock = ~clock;
  servo_direction_pitch_config i_dut (.CLOCK(clock), .RESET_N(reset_n), .RESTART(restart),
    .DIRECTION_SELECT_FIELD(dir), .SCALE_PITCH_SETTING(pitch), .LINEAR_MOTOR(lin),
    .CONVERTER_PRESENT(conv), .AUTO_PITCH(23'h001234), .ENCODER_PARAMS_PRESENT(encp),
    .MOTOR_PARAMS_PRESENT(motp), .ENCODER_SERIAL(56'h0123456789ABCD), .FORWARD_STEP(fwd),
    .REVERSE_STEP(rev), .FORWARD_TRAVEL_LIMIT(flim), .REVERSE_TRAVEL_LIMIT(rlim),
    .MOTOR_STEP(mstep), .MOTOR_CCW(ccw), .LIMIT_BLOCKED(blk), .DIVIDED_PULSE_A_OUT(pa),
    .DIVIDED_PULSE_B_OUT(pb), .ACTIVE_PITCH(apitch), .PITCH_ALARM(palm),
    .ENCODER_PARAM_ALARM(ealm), .MOTOR_PARAM_ALARMS(malm), .SERIAL_MONITOR(ser));
  motion_ctrl_model i_ctrl (.clock(clock), .cmd(cmd), .pa(pa), .pb(pb), .fwd(fwd),
    .rev(rev), .pos(pos));
  task tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  task cmp(input string nm, input logic [55:0] e, input logic [55:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_fail++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask : cmp
  task cfg(input logic l, c, e, m, d, input logic [22:0] p);
    lin = l;
    conv = c;
    encp = e;
    motp = m;
    dir = d;
    pitch = p;
    restart = 1;
    tick(1);
    restart = 0;
    tick(2);
  endtask : cfg
  task go(input logic [1:0] c, input int n);
    cmd = c;
    tick(n);
  endtask : go
  task end_sim;
    if (n_fail == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  initial
  begin
    #100000;
    n_fail++;
    end_sim;
  end
  initial
  begin
    tick(6);
    reset_n = 1;
    tick(2);
    cfg(0, 0, 1, 1, 0, 23'h0);
    // rotary: serial passes through, pitch stays at default
    cmp("ser", 56'h0123456789ABCD, ser);
    cmp("pitch", `PITCH_DEFAULT, apitch);
    go(1, 1);
    cmp("ccw", 1, ccw);
    go(1, 3);
    go(0, 2);
    cmp("pos", 4, pos);
    dir = 1;
    go(1, 1);
    cmp("ccw", 1, ccw);
    go(0, 1);
    cfg(0, 0, 1, 1, 1, 23'h0);
    go(1, 1);
    cmp("ccw", 0, ccw);
    go(2, 1);
    cmp("ccw", 1, ccw);
    go(0, 2);
    cmp("pos", 5, pos);
    flim = 1;
    go(1, 1);
    cmp("blk", 1, blk);
    go(2, 1);
    cmp("step", 1, mstep);
    flim = 0;
    rlim = 1;
    go(2, 1);
    cmp("blk", 1, blk);
    rlim = 0;
    go(0, 1);
    cfg(1, 1, 1, 1, 0, 23'h0);
    cmp("palm", 1, palm);
    go(1, 1);
    cmp("step", 0, mstep);
    go(0, 1);
    cfg(1, 1, 1, 1, 0, 23'h7FFFFF);
    cmp("pitch", `PITCH_MAX, apitch);
    cmp("palm", 0, palm);
    go(1, 1);
    cmp("ccw", 1, ccw);
    go(0, 1);
    cfg(1, 1, 1, 1, 1, 23'h0007D0);
    cmp("pitch", 23'h0007D0, apitch);
    go(1, 1);
    cmp("ccw", 0, ccw);
    go(0, 1);
    cfg(1, 0, 1, 1, 0, 23'h0);
    cmp("pitch", 23'h001234, apitch);
    cmp("palm", 0, palm);
    cmp("ser", `SERIAL_PLACEHOLDER, ser);
    cfg(1, 0, 0, 1, 0, 23'h0);
    cmp("ealm", 1, ealm);
    cfg(1, 0, 1, 0, 0, 23'h0);
    cmp("malm", 1, malm);
    cmp("ealm", 0, ealm);
    end_sim;
  end
endmodule : servo_direction_pitch_config_tb
`default_nettype wire
